// ---- ecmc_defines.svh ----
`ifndef ECMC_DEFINES_SVH
`define ECMC_DEFINES_SVH
// register byte addresses on the avalon slave
`define ECMC_OFS_CONTROL 4'h0
`define ECMC_OFS_CAPTURE 4'h4
`define ECMC_OFS_FLAGS 4'h8
`define ECMC_OFS_TIMER 4'hc
// control register fields
`define ECMC_MODE_LSB 0
`define ECMC_MODE_MSB 3
`define ECMC_DUTY_LSB 4
`define ECMC_DUTY_MSB 5
`define ECMC_OCFG_LSB 6
`define ECMC_OCFG_MSB 7
`define ECMC_CONTROL_RESET 8'h00
// flag register fields
`define ECMC_FLAG_EVENT 0
`define ECMC_FLAG_OVF 1
// mode select codes
`define ECMC_M_OFF 4'h0
`define ECMC_M_TOGGLE 4'h2
`define ECMC_M_FALL 4'h4
`define ECMC_M_RISE 4'h5
`define ECMC_M_RISE4 4'h6
`define ECMC_M_RISE16 4'h7
`define ECMC_M_SET 4'h8
`define ECMC_M_CLEAR 4'h9
`define ECMC_M_SOFT 4'ha
`define ECMC_M_SPECIAL 4'hb
// prescale terminal counts
`define ECMC_PRE4_LAST 4'h3
`define ECMC_PRE16_LAST 4'hf
`endif

// ---- ecmc_partner.sv ----
`timescale 1ns/100ps
module ecmc_partner
(
  // system
  input wire logic clock,
  input wire logic resetn,
  // bench commands
  input wire logic pin_level,
  input wire logic load,
  input wire logic [15:0] load_val,
  // device side
  input wire logic timer_one_reset,
  output logic unit_pin,
  output logic [15:0] timer_one_count
);
  // pad follows the commanded level one clock later
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      unit_pin <= 1'b0;
    else
      unit_pin <= pin_level;
  // timer held still unless loaded or cleared by timer_one_reset, so captured values are known
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      timer_one_count <= 16'h0000;
    else if (timer_one_reset)
      timer_one_count <= 16'h0000;
    else if (load)
      timer_one_count <= load_val;
endmodule

// ---- ecmc_pkg.sv ----
package ecmc_pkg;
  typedef struct packed {
    logic [1:0] output_config_field;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_select;
  } ecmc_control_s;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } ecmc_bridge_s;

  typedef enum logic [1:0] {
    ECMC_CLS_OFF,
    ECMC_CLS_CAPTURE,
    ECMC_CLS_COMPARE,
    ECMC_CLS_PWM
  } ecmc_class_e;
endpackage

// ---- ecmc_unit.sv ----
`timescale 1ns/100ps
`include "ecmc_defines.svh"

module ecmc_unit
(
  // system
  input wire logic clock,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // timer one and converter
  input wire logic [15:0] timer_one_count,
  input wire logic timer_one_overflow,
  input wire logic adc_enabled,
  output logic timer_one_reset,
  output logic adc_start,
  // pwm engine outputs, active-high, dead-time applied outside
  input wire logic pwm_primary,
  input wire logic pwm_complement,
  // unit pin level, as seen at the pad
  input wire logic unit_pin,
  // duty word for the external pwm engine
  output logic [9:0] pwm_duty,
  // bridge outputs and ownership
  output ecmc_pkg::ecmc_bridge_s bridge_out,
  output ecmc_pkg::ecmc_bridge_s bridge_owned,
  output ecmc_pkg::ecmc_class_e unit_class
);
  import ecmc_pkg::*;

  ecmc_control_s ctl_q;
  logic [15:0] cap_q;
  logic flag_q;
  logic ovf_q;
  logic sync1_q;
  logic sync2_q;
  logic last_q;
  logic [3:0] pre_q;
  logic cmp_q;
  logic seen_match_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [3:0] mode;
  logic is_capture;
  logic is_compare;
  logic is_pwm;
  logic rise;
  logic fall;
  logic cap_strobe;
  logic match;
  logic match_event;
  logic wr_ctl;
  logic wr_cap;
  logic wr_flags;
  logic sel_rd;
  logic pre_last;

  assign mode = ctl_q.unit_mode_select;
  assign is_pwm = (mode[3:2] == 2'b11);
  assign is_capture = (mode[3:2] == 2'b01);
  assign is_compare = (mode == `ECMC_M_TOGGLE) || (mode[3:2] == 2'b10);
  assign unit_class = is_pwm ? ECMC_CLS_PWM :
                      is_capture ? ECMC_CLS_CAPTURE :
                      is_compare ? ECMC_CLS_COMPARE : ECMC_CLS_OFF;

  // bus: one wait cycle, then a single acked cycle
  assign sel_rd = avs_read && !ack_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_ctl = avs_write && ack_q && avs_address == `ECMC_OFS_CONTROL;
  assign wr_cap = avs_write && ack_q && avs_address == `ECMC_OFS_CAPTURE;
  assign wr_flags = avs_write && ack_q && avs_address == `ECMC_OFS_FLAGS;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read || avs_write) && !ack_q;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 32'h0;
    else if (sel_rd)
    begin
      unique case (avs_address)
        `ECMC_OFS_CONTROL: rdata_q <= {24'h0, ctl_q};
        `ECMC_OFS_CAPTURE: rdata_q <= {16'h0, cap_q};
        `ECMC_OFS_FLAGS: rdata_q <= {30'h0, ovf_q, flag_q};
        `ECMC_OFS_TIMER: rdata_q <= {16'h0, timer_one_count};
        default: rdata_q <= 32'h0;
      endcase
    end
  end
  assign avs_readdata = rdata_q;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ctl_q <= `ECMC_CONTROL_RESET;
    else if (wr_ctl)
      ctl_q <= avs_writedata[7:0];
  end

  // pin synchroniser; pad level is read whatever the pin direction
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      sync1_q <= unit_pin;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end
  assign rise = sync2_q && !last_q;
  assign fall = !sync2_q && last_q;

  assign pre_last = (mode == `ECMC_M_RISE4) ? (pre_q == `ECMC_PRE4_LAST) :
                    (pre_q == `ECMC_PRE16_LAST);

  // prescaler keeps its count across a prescale change: false events possible
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      pre_q <= 4'h0;
    else if (!is_capture)
      pre_q <= 4'h0;
    else if (rise && mode[1])
      pre_q <= pre_last ? 4'h0 : pre_q + 4'h1;
  end

  always_comb
  begin
    cap_strobe = 1'b0;
    unique case (mode)
      `ECMC_M_FALL: cap_strobe = fall;
      `ECMC_M_RISE: cap_strobe = rise;
      `ECMC_M_RISE4, `ECMC_M_RISE16: cap_strobe = rise && pre_last;
      default: cap_strobe = 1'b0;
    endcase
  end

  // capture register doubles as compare value and pwm duty high byte
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      cap_q <= 16'h0;
    else if (cap_strobe)
      cap_q <= timer_one_count;
    else if (wr_cap)
      cap_q <= avs_writedata[15:0];
  end

  assign match = is_compare && (timer_one_count == cap_q);
  // one event per match episode
  assign match_event = match && !seen_match_q;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      seen_match_q <= 1'b0;
    else
      seen_match_q <= match;
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      flag_q <= 1'b0;
    else if (cap_strobe || match_event)
      flag_q <= 1'b1;
    else if (wr_flags && avs_writedata[`ECMC_FLAG_EVENT])
      flag_q <= 1'b0;
  end

  // overflow flag comes only from timer one overflow, never the trigger
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ovf_q <= 1'b0;
    else if (timer_one_overflow)
      ovf_q <= 1'b1;
    else if (wr_flags && avs_writedata[`ECMC_FLAG_OVF])
      ovf_q <= 1'b0;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      cmp_q <= 1'b0;
    else if (mode == `ECMC_M_OFF)
      cmp_q <= 1'b0;
    else if (match_event)
    begin
      unique case (mode)
        `ECMC_M_TOGGLE: cmp_q <= !cmp_q;
        `ECMC_M_SET: cmp_q <= 1'b1;
        `ECMC_M_CLEAR: cmp_q <= 1'b0;
        default: cmp_q <= cmp_q;
      endcase
    end
  end

  // timer reset is sampled at the next edge only if match still holds
  assign timer_one_reset = match && mode == `ECMC_M_SPECIAL;
  assign adc_start = match_event && mode == `ECMC_M_SPECIAL && adc_enabled;

  always_comb
  begin
    logic inv_ac;
    logic inv_bd;
    inv_ac = ctl_q.unit_mode_select[1];
    inv_bd = ctl_q.unit_mode_select[0];
    bridge_out = '0;
    bridge_owned = '0;
    if (!is_pwm)
    begin
      bridge_out.a = cmp_q;
      bridge_owned.a = is_compare && mode != `ECMC_M_SOFT &&
                       mode != `ECMC_M_SPECIAL;
    end
    else
    begin
      unique case (ctl_q.output_config_field)
        2'b00:
        begin
          bridge_out.a = pwm_primary ^ inv_ac;
          bridge_owned.a = 1'b1;
        end
        2'b01:
        begin
          bridge_out = {1'b1 ^ inv_ac, inv_bd, inv_ac,
                        pwm_primary ^ inv_bd};
          bridge_owned = 4'hf;
        end
        2'b10:
        begin
          bridge_out.a = pwm_primary ^ inv_ac;
          bridge_out.b = pwm_complement ^ inv_bd;
          bridge_owned = 4'hc;
        end
        2'b11:
        begin
          bridge_out = {inv_ac, pwm_primary ^ inv_bd,
                        1'b1 ^ inv_ac, inv_bd};
          bridge_owned = 4'hf;
        end
      endcase
    end
  end

  // capture low byte doubles as the duty high bits in pwm mode
  assign pwm_duty = {cap_q[7:0], ctl_q.duty_low_bits};

  chk_off_clears: assert property (@(posedge clock)
    disable iff (!resetn)
    ctl_q == 8'h00 |=> !cmp_q && pre_q == 4'h0)
    else $error("off mode left compare latch or prescaler set");
  chk_capture_copy: assert property (@(posedge clock)
    disable iff (!resetn)
    cap_strobe |=> cap_q == $past(timer_one_count) && flag_q)
    else $error("capture did not copy timer");
  chk_flag_sticky: assert property (@(posedge clock)
    disable iff (!resetn)
    flag_q && !wr_flags |=> flag_q)
    else $error("event flag cleared by hardware");
  chk_rise_capture: assert property (@(posedge clock)
    disable iff (!resetn)
    mode == `ECMC_M_RISE && sync2_q && !last_q |-> cap_strobe)
    else $error("rising edge missed");
  chk_prescale_four: assert property (@(posedge clock)
    disable iff (!resetn)
    mode == `ECMC_M_RISE4 && cap_strobe |-> $past(pre_q) <= 4'h3)
    else $error("prescale four out of range");
  chk_prescale_clear: assert property (@(posedge clock)
    disable iff (!resetn)
    !is_capture |=> pre_q == 4'h0)
    else $error("prescaler not cleared");
  chk_toggle_match: assert property (@(posedge clock)
    disable iff (!resetn)
    match_event && mode == `ECMC_M_TOGGLE && !wr_ctl
    |=> cmp_q != $past(cmp_q) && flag_q)
    else $error("toggle on match failed");
  chk_set_match: assert property (@(posedge clock)
    disable iff (!resetn)
    match_event && mode == `ECMC_M_SET && !wr_ctl |=> cmp_q)
    else $error("set on match failed");
  chk_soft_pin: assert property (@(posedge clock)
    disable iff (!resetn)
    mode == `ECMC_M_SOFT |-> !bridge_owned.a)
    else $error("soft interrupt mode drives pin");
  chk_special_adc: assert property (@(posedge clock)
    disable iff (!resetn)
    adc_start |-> adc_enabled && timer_one_reset)
    else $error("converter started wrongly");
  chk_single_a: assert property (@(posedge clock)
    disable iff (!resetn)
    is_pwm && ctl_q.output_config_field == 2'b00
    |-> bridge_owned == 4'h8)
    else $error("single output owns extra pins");
  chk_reverse_bridge: assert property (@(posedge clock)
    disable iff (!resetn)
    is_pwm && ctl_q.output_config_field == 2'b11 && mode[1:0] == 2'b00
    |-> bridge_out.c && !bridge_out.a && !bridge_out.d)
    else $error("reverse bridge levels wrong");
  chk_clear_match: assert property (@(posedge clock)
    disable iff (!resetn)
    match_event && mode == `ECMC_M_CLEAR |=> !cmp_q)
    else $error("clear on match failed");
  chk_fall_capture: assert property (@(posedge clock)
    disable iff (!resetn)
    mode == `ECMC_M_FALL |-> cap_strobe == (!sync2_q && last_q))
    else $error("falling edge capture wrong");
  chk_strobe_single: assert property (@(posedge clock)
    disable iff (!resetn)
    cap_strobe && !wr_ctl |=> !cap_strobe)
    else $error("capture strobe longer than one cycle");
  chk_ovf_source: assert property (@(posedge clock)
    disable iff (!resetn)
    !ovf_q && !timer_one_overflow |=> !ovf_q)
    else $error("overflow flag set without timer overflow");
  chk_forward_bridge: assert property (@(posedge clock)
    disable iff (!resetn)
    is_pwm && ctl_q.output_config_field == 2'b01 && mode[1:0] == 2'b00
    |-> bridge_out == {3'b100, pwm_primary})
    else $error("forward bridge levels wrong");
  chk_half_pair: assert property (@(posedge clock)
    disable iff (!resetn)
    is_pwm && ctl_q.output_config_field == 2'b10 |-> bridge_owned == 4'hc)
    else $error("half bridge owns wrong pins");
  chk_plain_pins: assert property (@(posedge clock)
    disable iff (!resetn)
    !is_pwm |-> !bridge_owned.b && !bridge_owned.c && !bridge_owned.d)
    else $error("non-pwm mode owns port pins");
endmodule

// ---- enhanced_capture_mode_control_tb_top.sv ----
`timescale 1ns/100ps
`include "ecmc_defines.svh"
module enhanced_capture_mode_control_tb_top;
  import ecmc_pkg::*;
  logic clock, resetn, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic timer_one_overflow, adc_enabled, timer_one_reset, adc_start;
  logic pwm_primary, pwm_complement, unit_pin, pin_level, load;
  logic [15:0] load_val, timer_one_count;
  logic [9:0] pwm_duty;
  ecmc_bridge_s bridge_out, bridge_owned;
  ecmc_class_e unit_class;
  int n_errors, n_compared, n_adc, n_rst;
  typedef struct {logic [7:0] c; logic p; logic [3:0] o, w;} ecmc_row_s;
  // control, primary level, masked outputs {a,b,c,d}, owned pins
  ecmc_row_s rows[8] = '{
    '{8'h1c, 1'b1, 4'h8, 4'h8}, '{8'h2e, 1'b1, 4'h0, 4'h8},
    '{8'h5c, 1'b1, 4'h9, 4'hf}, '{8'h7f, 1'b1, 4'h6, 4'hf},
    '{8'h8c, 1'b1, 4'h8, 4'hc}, '{8'hbd, 1'b1, 4'hc, 4'hc},
    '{8'hcc, 1'b1, 4'h6, 4'hf}, '{8'hfe, 1'b0, 4'h8, 4'hf}};
  ecmc_unit i_ecmc_unit (.clock, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .timer_one_count, .timer_one_overflow, .adc_enabled, .timer_one_reset,
    .adc_start, .pwm_primary, .pwm_complement, .unit_pin, .bridge_out,
    .bridge_owned, .unit_class, .pwm_duty);
  ecmc_partner i_ecmc_partner (.clock, .resetn, .pin_level, .load,
    .load_val, .timer_one_reset, .unit_pin, .timer_one_count);
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // single-cycle strobes are counted at the edge that samples them
  always @(posedge clock)
  begin
    if (adc_start === 1'b1)
      n_adc++;
    if (timer_one_reset === 1'b1)
      n_rst++;
  end
  task automatic chk(logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // no cap on the wait: only the watchdog ends a hung request
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdchk(logic [3:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic ctl(logic [7:0] v);
    bus(1'b1, `ECMC_OFS_CONTROL, 32'(v));
  endtask
  task automatic clr;
    bus(1'b1, `ECMC_OFS_FLAGS, 32'h1);
  endtask
  task automatic pin(logic v);
    pin_level <= v;
    repeat (8) @(posedge clock);
  endtask
  task automatic edges(int n);
    repeat (n)
    begin
      pin(1'b0);
      pin(1'b1);
    end
  endtask
  // timer steps onto v from one below, so a match starts cleanly
  task automatic hit(logic [15:0] v);
    load_val <= v - 16'h1;
    load <= 1'b1;
    @(posedge clock);
    load_val <= v;
    @(posedge clock);
    load <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  initial
  begin
    resetn = 1'b0;
    {avs_read, avs_write, timer_one_overflow, adc_enabled, load} = 5'h00;
    {pwm_primary, pwm_complement, pin_level} = 3'h2;
    {avs_address, avs_writedata, load_val} = 52'h0;
    {n_errors, n_compared, n_adc, n_rst} = '0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    rdchk(`ECMC_OFS_CONTROL, 32'h0);
    rdchk(`ECMC_OFS_FLAGS, 32'h0);
    chk(32'(bridge_owned), 32'h0);
    rdchk(4'h1, 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      ctl(rows[i].c);
      pwm_primary <= rows[i].p;
      pwm_complement <= !rows[i].p;
      repeat (2) @(posedge clock);
      chk(32'(bridge_owned), 32'(rows[i].w));
      chk(32'(bridge_out & bridge_owned), 32'(rows[i].o));
      chk(32'(unit_class), 32'(ECMC_CLS_PWM));
      chk(32'(pwm_duty), 32'(rows[i].c[5:4]));
      rdchk(`ECMC_OFS_CONTROL, 32'(rows[i].c));
    end
    for (int m = 0; m < 12; m++)
      if (m != 1 && m != 3)
      begin
        ctl({4'hc, 4'(m)});
        repeat (2) @(posedge clock);
        chk(32'(bridge_owned) & 32'h7, 32'h0);
        chk(32'(unit_class), m == 0 ? 32'(ECMC_CLS_OFF) : (m > 3 && m < 8) ?
          32'(ECMC_CLS_CAPTURE) : 32'(ECMC_CLS_COMPARE));
      end
    $display("mode table test done");
    ctl(8'h00);
    ctl(8'h05);
    clr;
    hit(16'h1234);
    pin(1'b1);
    rdchk(`ECMC_OFS_CAPTURE, 32'h1234);
    hit(16'h5678);
    edges(1);
    rdchk(`ECMC_OFS_CAPTURE, 32'h5678);
    rdchk(`ECMC_OFS_FLAGS, 32'h1);
    clr;
    rdchk(`ECMC_OFS_FLAGS, 32'h0);
    ctl(8'h04);
    hit(16'h0abc);
    pin(1'b0);
    hit(16'h0def);
    pin(1'b1);
    rdchk(`ECMC_OFS_CAPTURE, 32'h0abc);
    $display("capture test done");
    ctl(8'h06);
    clr;
    edges(2);
    // leaving the mode must drop the two edges already counted
    ctl(8'h00);
    ctl(8'h06);
    clr;
    edges(3);
    rdchk(`ECMC_OFS_FLAGS, 32'h0);
    edges(1);
    rdchk(`ECMC_OFS_FLAGS, 32'h1);
    ctl(8'h00);
    ctl(8'h07);
    clr;
    edges(15);
    rdchk(`ECMC_OFS_FLAGS, 32'h0);
    edges(1);
    rdchk(`ECMC_OFS_FLAGS, 32'h1);
    $display("prescale test done");
    ctl(8'h00);
    bus(1'b1, `ECMC_OFS_CAPTURE, 32'h0040);
    ctl(8'h08);
    chk(32'(pwm_duty), 32'h100);
    clr;
    hit(16'h0040);
    chk(32'(bridge_out.a), 32'h1);
    rdchk(`ECMC_OFS_FLAGS, 32'h1);
    ctl(8'h09);
    hit(16'h0040);
    chk(32'(bridge_out.a), 32'h0);
    ctl(8'h02);
    clr;
    hit(16'h0040);
    chk(32'(bridge_out.a), 32'h1);
    hit(16'h0040);
    chk(32'(bridge_out.a), 32'h0);
    hit(16'h0040);
    rdchk(`ECMC_OFS_FLAGS, 32'h1);
    ctl(8'h00);
    repeat (2) @(posedge clock);
    chk(32'(bridge_out.a), 32'h0);
    ctl(8'h0a);
    clr;
    hit(16'h0040);
    rdchk(`ECMC_OFS_FLAGS, 32'h1);
    chk(32'(bridge_owned.a), 32'h0);
    $display("compare test done");
    ctl(8'h0b);
    clr;
    adc_enabled <= 1'b1;
    n_adc = 0;
    n_rst = 0;
    hit(16'h0040);
    chk(32'(n_adc), 32'h1);
    chk(32'(n_rst), 32'h1);
    chk(32'(timer_one_count), 32'h0);
    rdchk(`ECMC_OFS_FLAGS, 32'h1);
    adc_enabled <= 1'b0;
    hit(16'h0040);
    chk(32'(n_adc), 32'h1);
    timer_one_overflow <= 1'b1;
    @(posedge clock);
    timer_one_overflow <= 1'b0;
    rdchk(`ECMC_OFS_FLAGS, 32'h3);
    rdchk(`ECMC_OFS_TIMER, 32'h0);
    $display("special event test done");
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rdchk(`ECMC_OFS_CONTROL, 32'h0);
    rdchk(`ECMC_OFS_FLAGS, 32'h0);
    $display("mid-run reset test done");
    test_done;
  end
  initial
  begin
    repeat (30000) @(posedge clock);
    n_errors++;
    test_done;
  end
endmodule
